// File: hw/psm_defs.vh
// constants for the power-state manager
`ifndef PSM_DEFS_VH
`define PSM_DEFS_VH
// power states
`define PSM_ST_BOOT 3'h0
`define PSM_ST_ACTIVE 3'h1
`define PSM_ST_IDLE 3'h2
`define PSM_ST_SLEEP 3'h3
// core clock rate selection codes
`define PSM_CLK_12M 2'h0
`define PSM_CLK_5M 2'h1
`define PSM_CLK_100K 2'h2
// core clock rates in kHz per state
`define PSM_RATE_ACTIVE_KHZ 16'h2EE0
`define PSM_RATE_IDLE_KHZ 16'h1388
`define PSM_RATE_SLEEP_KHZ 16'h0064
// host commands
`define PSM_CMD_NONE 2'h0
`define PSM_CMD_SLEEP 2'h1
`define PSM_CMD_WAKE 2'h2
`define PSM_CMD_IDLE 2'h3
`endif

// File: hw/psm_power_manager.v
// power-state manager of the type-c / pd controller core
`timescale 1ns/10ps
`include "psm_defs.vh"

// Notes on behaviour
// - Core clock is 12 MHz active, about 5 MHz idle, 100 kHz sleep; slow osc always on, fast off in sleep.
// - PD traffic wakes idle to active but never wakes sleep.
// - The PD message that wakes the core from idle is dropped; later ones pass.
// - Addressed I2C traffic or attach/detach wakes the core from idle or sleep.
// - With the regulated 3.3 V rail fed from the bus supply, the port acts only as a sink.
// - During boot a config bundle is accepted over I2C or SPI before normal operation.
// - A host command port over I2C controls the power state while the core is active or idle.
module psm_power_manager #(
   parameter IDLE_TIMEOUT = 16'h0400
) (
   // clock and reset
   input wire core_clk,
   input wire resetn,
   // pins from outside the clock domain
   input wire cable_attached,
   input wire rail_from_bus,
   // traffic start strobes from the phy and serial front ends
   input wire pd_msg_valid,
   input wire i2c_addr_match,
   input wire spi_activity,
   // configuration bundle load during boot
   input wire cfg_i2c_done,
   input wire cfg_spi_done,
   // host command port from the i2c front end
   input wire host_cmd_valid,
   input wire [1:0] host_cmd,
   // state and clock control
   output reg [2:0] power_state,
   output reg [1:0] core_clk_sel,
   output reg [15:0] core_rate_khz,
   output wire osc_100k_en,
   output reg osc_24m_en,
   // traffic gates
   output reg pd_enable,
   output reg i2c_enable,
   output reg spi_enable,
   output wire typec_detect_en,
   output wire pd_msg_accept,
   output wire host_cmd_ready,
   // power role
   output reg sink_only,
   output reg source_path_allowed,
   output reg cfg_loaded
);
   // ****************************************
   // pin synchronisers
   // ****************************************
   wire [1:0] pins_sync;
   wire attached;
   wire bus_rail;

   psm_sync #(.WIDTH(2)) u_sync (
      .core_clk(core_clk),
      .resetn(resetn),
      .pin({rail_from_bus, cable_attached}),
      .level(pins_sync)
   );
   assign attached = pins_sync[0];
   assign bus_rail = pins_sync[1];

   // ****************************************
   // state machine
   // ****************************************
   localparam ST_BOOT = `PSM_ST_BOOT;
   localparam ST_ACTIVE = `PSM_ST_ACTIVE;
   localparam ST_IDLE = `PSM_ST_IDLE;
   localparam ST_SLEEP = `PSM_ST_SLEEP;

   reg [2:0] next_power_state;
   reg attached_q;
   reg [15:0] idle_cnt;
   reg sleep_req;
   wire attach_event;
   wire wake_any;
   wire cmd_sleep;
   wire cmd_wake;
   wire cmd_idle;

   assign attach_event = attached ^ attached_q;
   // wake sources common to idle and sleep
   assign wake_any = i2c_addr_match | attach_event;
   assign host_cmd_ready = (power_state == ST_ACTIVE) || (power_state == ST_IDLE);
   assign cmd_sleep = host_cmd_valid & host_cmd_ready & (host_cmd == `PSM_CMD_SLEEP);
   assign cmd_wake = host_cmd_valid & host_cmd_ready & (host_cmd == `PSM_CMD_WAKE);
   assign cmd_idle = host_cmd_valid & host_cmd_ready & (host_cmd == `PSM_CMD_IDLE);

   // next state decision
   always @* begin
      next_power_state = power_state;
      case (power_state)
         ST_BOOT: begin
            if (cfg_i2c_done || cfg_spi_done) begin
               next_power_state = ST_ACTIVE;
            end
         end
         ST_ACTIVE: begin
            // sleep only while unconnected, else stay active until an idle command or the idle timeout
            if ((sleep_req || cmd_sleep) && !attached) begin
               next_power_state = ST_SLEEP;
            end else if (cmd_idle || idle_cnt == IDLE_TIMEOUT) begin
               next_power_state = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (wake_any || pd_msg_valid || cmd_wake) begin
               next_power_state = ST_ACTIVE;
            end else if ((sleep_req || cmd_sleep) && !attached) begin
               next_power_state = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            // pd traffic deliberately ignored here
            if (wake_any) begin
               next_power_state = ST_ACTIVE;
            end
         end
         default: begin
            next_power_state = ST_BOOT;
         end
      endcase
   end

   // state, attach history, idle counter, pending sleep request
   always @(posedge core_clk) begin
      if (!resetn) begin
         power_state <= ST_BOOT;
         attached_q <= 1'b0;
         idle_cnt <= 16'h0000;
         sleep_req <= 1'b0;
      end else begin
         power_state <= next_power_state;
         attached_q <= attached;
         // any traffic restarts the inactivity count
         if (power_state != ST_ACTIVE || pd_msg_valid || i2c_addr_match || spi_activity
             || host_cmd_valid) begin
            idle_cnt <= 16'h0000;
         end else if (idle_cnt != IDLE_TIMEOUT) begin
            idle_cnt <= idle_cnt + 16'h0001;
         end
         // sleep request held until sleep is reached or wake asked; wake wins
         if (cmd_wake || next_power_state == ST_SLEEP) begin
            sleep_req <= 1'b0;
         end else if (cmd_sleep) begin
            sleep_req <= 1'b1;
         end
      end
   end

   // ****************************************
   // clock, oscillator and feature gating
   // ****************************************
   assign osc_100k_en = 1'b1;
   assign typec_detect_en = 1'b1;
   // the waking pd message is dropped: gate uses the current state only
   assign pd_msg_accept = pd_msg_valid & (power_state == ST_ACTIVE);

   // registered controls follow the state
   always @(posedge core_clk) begin
      if (!resetn) begin
         core_clk_sel <= `PSM_CLK_12M;
         core_rate_khz <= `PSM_RATE_ACTIVE_KHZ;
         osc_24m_en <= 1'b1;
         pd_enable <= 1'b0;
         i2c_enable <= 1'b1;
         spi_enable <= 1'b1;
         sink_only <= 1'b0;
         // role outputs stay complementary through reset, bus rail reads low
         source_path_allowed <= 1'b1;
         cfg_loaded <= 1'b0;
      end else begin
         // boot runs at full rate with both config buses open
         case (next_power_state)
            ST_IDLE: begin
               core_clk_sel <= `PSM_CLK_5M;
               core_rate_khz <= `PSM_RATE_IDLE_KHZ;
               osc_24m_en <= 1'b1;
               pd_enable <= 1'b0;
               i2c_enable <= 1'b1;
               spi_enable <= 1'b0;
            end
            ST_SLEEP: begin
               core_clk_sel <= `PSM_CLK_100K;
               core_rate_khz <= `PSM_RATE_SLEEP_KHZ;
               osc_24m_en <= 1'b0;
               pd_enable <= 1'b0;
               i2c_enable <= 1'b0;
               spi_enable <= 1'b0;
            end
            ST_ACTIVE: begin
               core_clk_sel <= `PSM_CLK_12M;
               core_rate_khz <= `PSM_RATE_ACTIVE_KHZ;
               osc_24m_en <= 1'b1;
               pd_enable <= 1'b1;
               i2c_enable <= 1'b1;
               spi_enable <= 1'b1;
            end
            default: begin
               core_clk_sel <= `PSM_CLK_12M;
               core_rate_khz <= `PSM_RATE_ACTIVE_KHZ;
               osc_24m_en <= 1'b1;
               pd_enable <= 1'b0;
               i2c_enable <= 1'b1;
               spi_enable <= 1'b1;
            end
         endcase
         // role limited while powered from the bus
         sink_only <= bus_rail;
         source_path_allowed <= ~bus_rail;
         if (power_state == ST_BOOT && next_power_state == ST_ACTIVE) begin
            cfg_loaded <= 1'b1;
         end
      end
   end
endmodule // psm_power_manager

// File: hw/psm_sync.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module psm_sync #(
   parameter WIDTH = 1
) (
   // clock and reset
   input wire core_clk,
   input wire resetn,
   // raw pin and filtered level
   input wire [WIDTH-1:0] pin,
   output reg [WIDTH-1:0] level
);
   reg [WIDTH-1:0] s1;
   reg [WIDTH-1:0] s2;
   reg [WIDTH-1:0] s3;
   genvar i;

   // s1 only feeds s2, level changes when s2 and s3 agree
   always @(posedge core_clk) begin
      if (!resetn) begin
         s1 <= {WIDTH{1'b0}};
         s2 <= {WIDTH{1'b0}};
         s3 <= {WIDTH{1'b0}};
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
      end
   end

   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always @(posedge core_clk) begin
            if (!resetn) begin
               level[i] <= 1'b0;
            end else if (s2[i] == s3[i]) begin
               level[i] <= s3[i];
            end
         end
      end
   endgenerate
endmodule // psm_sync

// File: sim/psm_chk.sv
// assertions on the ports of the power-state manager
`timescale 1ns/10ps
`include "psm_defs.vh"
module psm_chk (
   // clock and reset
   input wire core_clk,
   input wire resetn,
   // watched inputs
   input wire cable_attached,
   input wire pd_msg_valid,
   input wire i2c_addr_match,
   // watched outputs
   input wire [2:0] power_state,
   input wire [15:0] core_rate_khz,
   input wire [1:0] core_clk_sel,
   input wire osc_100k_en,
   input wire osc_24m_en,
   input wire pd_enable,
   input wire i2c_enable,
   input wire spi_enable,
   input wire typec_detect_en,
   input wire pd_msg_accept,
   input wire sink_only,
   input wire source_path_allowed,
   input wire cfg_loaded
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // state decodes shared by the properties
   wire act = power_state == `PSM_ST_ACTIVE;
   wire idl = power_state == `PSM_ST_IDLE;
   wire slp = power_state == `PSM_ST_SLEEP;
   // expected clock select from the state alone
   wire [1:0] sel_exp = slp ? `PSM_CLK_100K : (idl ? `PSM_CLK_5M : `PSM_CLK_12M);
   chk_osc_per_state: assert property (osc_100k_en && (osc_24m_en == !slp))
      else $error("oscillator enable wrong for state");
   chk_rate_per_state: assert property ((act |-> core_rate_khz == `PSM_RATE_ACTIVE_KHZ) and
      (idl |-> core_rate_khz == `PSM_RATE_IDLE_KHZ) and (slp |-> core_rate_khz == 16'h0064))
      else $error("core rate wrong for state");
   chk_pd_wake_idle: assert property (idl && pd_msg_valid |=> act)
      else $error("pd traffic did not wake idle core");
   chk_pd_no_sleep: assert property (slp && pd_msg_valid && !i2c_addr_match |-> !pd_msg_accept)
      else $error("pd traffic handled in sleep");
   chk_first_msg_drop: assert property (pd_msg_accept |-> act && pd_msg_valid)
      else $error("pd message accepted outside active");
   chk_i2c_wake: assert property ((idl || slp) && i2c_addr_match |=> act)
      else $error("addressed i2c did not wake core");
   chk_sink_role: assert property (sink_only ^ source_path_allowed)
      else $error("power role outputs disagree");
   chk_cfg_before_run: assert property (power_state != `PSM_ST_BOOT |-> cfg_loaded)
      else $error("left boot without configuration");
   chk_traffic_gates: assert property (pd_enable == act && spi_enable == (act || !power_state))
      else $error("traffic gate wrong for state");
   chk_sleep_unconn: assert property (cable_attached [*8] |-> !slp)
      else $error("asleep while port connected");
   chk_clk_select: assert property (core_clk_sel == sel_exp)
      else $error("core clock select wrong for state");
   chk_i2c_gate: assert property (i2c_enable == !slp && typec_detect_en)
      else $error("i2c gate or detection wrong for state");
   // main scenarios reached
   cov_sleep_wake: cover property (slp ##1 act);
   cov_pd_idle: cover property (idl && pd_msg_valid);
   cov_sink: cover property (sink_only);
endmodule // psm_chk
bind psm_power_manager psm_chk chk_u (.core_clk, .resetn, .cable_attached, .pd_msg_valid,
   .i2c_addr_match, .power_state, .core_rate_khz, .core_clk_sel, .osc_100k_en, .osc_24m_en,
   .pd_enable, .i2c_enable, .spi_enable, .typec_detect_en, .pd_msg_accept, .sink_only,
   .source_path_allowed, .cfg_loaded);

// File: sim/psm_ec_model.sv
// embedded controller model on the host command port
`timescale 1ns/10ps
module psm_ec_model (
   // clock
   input wire core_clk,
   // host command port
   input wire host_cmd_ready,
   output reg host_cmd_valid,
   output reg [1:0] host_cmd
);
   initial begin
      host_cmd_valid = 1'b0;
      host_cmd = 2'h0;
   end
   // one-cycle command, issued only while the device listens
   task send(input [1:0] c);
      begin
         @(posedge core_clk);
         while (!host_cmd_ready) @(posedge core_clk);
         host_cmd_valid <= 1'b1;
         host_cmd <= c;
         // hold the command until the edge that sees the device listening
         @(posedge core_clk);
         while (!host_cmd_ready) @(posedge core_clk);
         host_cmd_valid <= 1'b0;
         host_cmd <= ~c; // stale code would hide a valid-gating fault
      end
   endtask
endmodule // psm_ec_model

// File: sim/tb_top.sv
// self-checking bench for the power-state manager
`timescale 1ns/10ps
`include "psm_defs.vh"
module tb_top;
   reg core_clk = 1'b0;
   reg resetn = 1'b0;
   reg cable_attached = 1'b0, rail_from_bus = 1'b0, pd_msg_valid = 1'b0;
   reg i2c_addr_match = 1'b0, spi_activity = 1'b0, cfg_spi_done = 1'b0, acc, r;
   reg cfg_i2c_done = 1'b0;
   wire host_cmd_valid, osc_24m_en, pd_msg_accept, host_cmd_ready, sink_only;
   wire [1:0] host_cmd;
   wire [2:0] power_state;
   wire [15:0] core_rate_khz;
   integer n_fail = 0, n_compared = 0, cyc = 0, i;
   always #12.5 core_clk = ~core_clk;
   // short idle timeout keeps the run brief
   psm_power_manager #(.IDLE_TIMEOUT(16'h0010)) dut_u (.core_clk, .resetn, .cable_attached,
      .rail_from_bus, .pd_msg_valid, .i2c_addr_match, .spi_activity, .cfg_i2c_done,
      .cfg_spi_done, .host_cmd_valid, .host_cmd, .power_state, .core_clk_sel(),
      .core_rate_khz, .osc_100k_en(), .osc_24m_en, .pd_enable(), .i2c_enable(), .spi_enable(),
      .typec_detect_en(), .pd_msg_accept, .host_cmd_ready, .sink_only,
      .source_path_allowed(), .cfg_loaded());
   psm_ec_model ec_u (.core_clk, .host_cmd_ready, .host_cmd_valid, .host_cmd);
   task conclude;
      begin
         if (n_fail == 0 && n_compared > 0) $display("bench passed");
         else $display("bench failed");
         $finish;
      end
   endtask
   task check(input [15:0] got, input [15:0] exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   function [15:0] exp_rate(input [2:0] st);
      exp_rate = (st == `PSM_ST_SLEEP) ? 16'h0064 : (st == `PSM_ST_IDLE) ? 16'h1388 : 16'h2EE0;
   endfunction
   task tick(input integer n);
      repeat (n) @(posedge core_clk);
   endtask
   // one-cycle strobe: 0 pd, 1 i2c, 2 spi; pd acceptance sampled in its cycle
   task strobe(input [1:0] k);
      begin
         @(posedge core_clk);
         {spi_activity, i2c_addr_match, pd_msg_valid} <= 3'h1 << k;
         #1 acc = pd_msg_accept;
         @(posedge core_clk);
         {spi_activity, i2c_addr_match, pd_msg_valid} <= 3'h0;
      end
   endtask
   // hang guard
   always @(posedge core_clk) begin
      cyc = cyc + 1;
      if (cyc == 4000) begin
         n_fail = n_fail + 1;
         conclude;
      end
   end
   initial begin
      i = $urandom(32'h615a);
      tick(10);
      resetn <= 1'b1;
      tick(1);
      cfg_spi_done <= 1'b1;
      tick(2);
      check(power_state, `PSM_ST_ACTIVE);
      strobe(0);
      check(acc, 1'b1);
      for (i = 0; i < 8; i = i + 1) begin
         tick(1 + $urandom % 10);
         strobe(2);
      end
      check(power_state, `PSM_ST_ACTIVE);
      tick(20);
      check(power_state, `PSM_ST_IDLE);
      check(core_rate_khz, exp_rate(`PSM_ST_IDLE));
      strobe(0);
      check(acc, 1'b0);
      // state moves on the strobe's last edge, so look one edge later
      tick(1);
      check(power_state, `PSM_ST_ACTIVE);
      strobe(0);
      check(acc, 1'b1);
      cable_attached <= 1'b1;
      tick(8);
      ec_u.send(`PSM_CMD_SLEEP);
      tick(4);
      check(power_state, `PSM_ST_ACTIVE);
      cable_attached <= 1'b0;
      tick(8);
      check(power_state, `PSM_ST_SLEEP);
      check(osc_24m_en, 1'b0);
      check(core_rate_khz, exp_rate(`PSM_ST_SLEEP));
      strobe(0);
      check(acc, 1'b0);
      tick(2);
      check(power_state, `PSM_ST_SLEEP);
      strobe(1);
      tick(1);
      check(power_state, `PSM_ST_ACTIVE);
      ec_u.send(`PSM_CMD_SLEEP);
      tick(3);
      cable_attached <= 1'b1;
      tick(8);
      check(power_state, `PSM_ST_ACTIVE);
      ec_u.send(`PSM_CMD_IDLE);
      tick(1);
      check(power_state, `PSM_ST_IDLE);
      ec_u.send(`PSM_CMD_WAKE);
      tick(1);
      check(power_state, `PSM_ST_ACTIVE);
      for (i = 0; i < 4; i = i + 1) begin
         // first pass pins the bus-powered corner
         r = (i == 0) ? 1'b1 : $urandom % 2;
         rail_from_bus <= r;
         tick(6);
         check(sink_only, r);
      end
      // mid-run reset, configuration over i2c this time
      resetn <= 1'b0;
      cfg_spi_done <= 1'b0;
      tick(10);
      resetn <= 1'b1;
      tick(2);
      check(power_state, `PSM_ST_BOOT);
      cfg_i2c_done <= 1'b1;
      tick(2);
      check(power_state, `PSM_ST_ACTIVE);
      conclude;
   end
endmodule // tb_top
